// >>> hdl/gips_cfg.svh
// offsets, field masks and reset values of the input polarity block
`ifndef GIPS_CFG_SVH
`define GIPS_CFG_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define GIPS_OFS_POLARITY   12'h02c
`define GIPS_OFS_STATUS     12'h030
`define GIPS_OFS_MASK       12'h034
`define GIPS_OFS_DIRECTION  12'h038
`define GIPS_OFS_LEVEL      12'h03c
// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define GIPS_RESUME_BITS    32'h0000_3900
`define GIPS_CORE_BITS      32'h0000_00db
`define GIPS_IMPL_BITS      32'h0000_39db
`define GIPS_POLARITY_RST   32'h0000_0000
`define GIPS_DIRECTION_RST  32'h0000_0000
`define GIPS_MASK_RST       32'h0000_0000
`endif

// >>> hdl/gips_pkg.sv
// types shared by the input polarity block
package gips_pkg;
    typedef logic [31:0] gips_word_t;
endpackage

// >>> hdl/gips_top.sv
// input polarity select with event status, mask and interrupt, apb slave
`timescale 1ns/100ps
`include "gips_cfg.svh"
module gips_top
    import gips_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        resume_well_reset,
    input  wire logic [31:0] gpio_pin,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             system_management_interrupt,
    output logic             power_management_interrupt
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    gips_word_t input_polarity_select;
    gips_word_t input_event_status;
    gips_word_t event_mask;
    gips_word_t pin_direction;
    gips_word_t pin_sync1;
    gips_word_t pin_level;
    logic       irq;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire logic wr_access = psel && penable && pwrite;
    wire logic hit_pol   = paddr == `GIPS_OFS_POLARITY;
    wire logic hit_sts   = paddr == `GIPS_OFS_STATUS;
    wire logic hit_msk   = paddr == `GIPS_OFS_MASK;
    wire logic hit_dir   = paddr == `GIPS_OFS_DIRECTION;
    wire logic hit_lvl   = paddr == `GIPS_OFS_LEVEL;
    wire logic hit_any   = hit_pol | hit_sts | hit_msk | hit_dir | hit_lvl;
    wire logic wr_pol    = wr_access && hit_pol;
    wire logic wr_sts    = wr_access && hit_sts;
    wire logic wr_msk    = wr_access && hit_msk;
    wire logic wr_dir    = wr_access && hit_dir;

    // writes to reserved positions are dropped
    wire gips_word_t pol_wdata = pwdata & `GIPS_IMPL_BITS;

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    // level after xor: 1 means the pin is at its programmed active level
    wire gips_word_t qualified =
        (pin_level ^ input_polarity_select) & ~pin_direction
        & `GIPS_IMPL_BITS;
    // set wins over a write-one clear in the same cycle
    wire gips_word_t next_status =
        (input_event_status & ~(wr_sts ? pwdata : 32'h0000_0000))
        | qualified;

    // polarity value after this cycle's write, before any reset is applied
    wire gips_word_t pol_written = wr_pol ? pol_wdata : input_polarity_select;
    // core reset only returns the core-well bits; resume bits keep their sense
    wire gips_word_t pol_after_core =
        (pol_written & `GIPS_RESUME_BITS)
        | (`GIPS_POLARITY_RST & ~`GIPS_RESUME_BITS);

    wire gips_word_t rd_mux =
        hit_pol ? input_polarity_select :
        hit_sts ? input_event_status :
        hit_msk ? event_mask :
        hit_dir ? pin_direction :
        hit_lvl ? pin_level : 32'h0000_0000;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        pin_sync1 <= gpio_pin;
        pin_level <= pin_sync1;
    end

    // ----------------------------------------------------------------
    // polarity register, split by power well
    // ----------------------------------------------------------------
    // resume bits survive the core reset so wake sources keep their sense
    always_ff @(posedge clock) begin
        if (resume_well_reset) begin
            input_polarity_select <= `GIPS_POLARITY_RST;
        end else if (srst) begin
            input_polarity_select <= pol_after_core;
        end else begin
            input_polarity_select <= pol_written;
        end
    end

    // ----------------------------------------------------------------
    // status, mask, direction
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || resume_well_reset) begin
            input_event_status <= 32'h0000_0000;
            event_mask         <= `GIPS_MASK_RST;
            pin_direction      <= `GIPS_DIRECTION_RST;
        end else begin
            input_event_status <= next_status;
            if (wr_msk) begin
                event_mask <= pwdata & `GIPS_IMPL_BITS;
            end
            if (wr_dir) begin
                pin_direction <= pwdata & `GIPS_IMPL_BITS;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt and apb answer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || resume_well_reset) begin
            irq    <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            irq <= |(input_event_status & event_mask);
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    assign system_management_interrupt = irq;
    assign power_management_interrupt  = irq;
    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;
endmodule

// >>> tb/gips_checker.sv
// concurrent checks on the ports of the input polarity block
`timescale 1ns/100ps
`include "gips_cfg.svh"
module gips_checker
    import gips_pkg::*;
(
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        resume_well_reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        system_management_interrupt,
    input wire logic        power_management_interrupt
);
    wire smi = system_management_interrupt;
    wire rd_pol = psel && !penable && !pwrite && paddr == `GIPS_OFS_POLARITY;
    default clocking @(posedge clock); endclocking
    default disable iff (resume_well_reset);
    irq_pair_a: assert property (smi == power_management_interrupt)
        else $error("interrupt outputs differ");
    core_clear_a: assert property (srst |=> !smi)
        else $error("interrupt survives core reset");
    // the interrupt lags a clearing write by one cycle, hence the past term
    irq_hold_a: assert property (smi && !psel && !$past(psel) && !srst |=> smi)
        else $error("interrupt dropped without software");
    rsvd_read_a: assert property (rd_pol |=> (prdata & ~`GIPS_IMPL_BITS) == 32'h0)
        else $error("reserved polarity bits read nonzero");
    core_rdata_a: assert property (srst |=> prdata == 32'h0000_0000)
        else $error("read data survives core reset");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    cover property ($rose(smi));
    cover property ($fell(smi));
    cover property (psel && penable && pslverr);
endmodule
bind gips_top gips_checker u_chk (.*);

// >>> tb/gips_pins.sv
// behavioural model of the external input pins
`timescale 1ns/100ps
module gips_pins
    import gips_pkg::*;
(
    input  wire logic       clock,
    input  wire gips_word_t level,
    output gips_word_t      gpio_pin
);
    // pins move after the edge, unrelated to when software looks
    initial gpio_pin = 32'h0;
    always @(posedge clock) gpio_pin <= level;
endmodule

// >>> tb/gips_tb_top.sv
// self-checking bench for the input polarity block
`timescale 1ns/100ps
`include "gips_cfg.svh"
module gips_tb_top;
    import gips_pkg::*;
    logic clock = 0, srst = 1, resume_well_reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    gips_word_t pwdata = 0, prdata, pins = 0, gpio_pin, rd;
    logic pready, pslverr, smi, pmi, err;
    int miscompares = 0, check_count = 0;
    gips_pins u_pins(.clock(clock), .level(pins), .gpio_pin(gpio_pin));
    gips_top u_dut(.clock(clock), .srst(srst), .resume_well_reset(resume_well_reset),
        .gpio_pin(gpio_pin), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .system_management_interrupt(smi), .power_management_interrupt(pmi));
    initial forever #50 clock = ~clock;
    task automatic chk(string n, gips_word_t s, gips_word_t e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, gips_word_t d);
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic t_high;
        apb(1, `GIPS_OFS_MASK, `GIPS_IMPL_BITS);
        pins <= 32'h1;
        repeat (6) @(posedge clock);
        pins <= 32'h0;
        repeat (6) @(posedge clock);
        chk("irq", {31'h0, smi}, 32'h1);
        chk("pmi", {31'h0, pmi}, 32'h1);
        apb(0, `GIPS_OFS_STATUS, 0);
        chk("status", rd, 32'h1);
        apb(1, `GIPS_OFS_STATUS, 32'h1);
        repeat (3) @(posedge clock);
        chk("irq", {31'h0, smi}, 32'h0);
        apb(0, 12'h100, 0);
        chk("slverr", {31'h0, err}, 32'h1);
    endtask
    task automatic t_low;
        apb(1, `GIPS_OFS_POLARITY, 32'h8);
        repeat (6) @(posedge clock);
        apb(0, `GIPS_OFS_STATUS, 0);
        chk("status", rd, 32'h8);
        apb(0, `GIPS_OFS_LEVEL, 0);
        chk("level", rd, 32'h0);
        apb(1, `GIPS_OFS_DIRECTION, 32'h8);
        apb(1, `GIPS_OFS_STATUS, 32'h8);
        repeat (6) @(posedge clock);
        apb(0, `GIPS_OFS_STATUS, 0);
        chk("status", rd, 32'h0);
    endtask
    task automatic t_wells;
        apb(1, `GIPS_OFS_POLARITY, 32'hffff_ffff);
        apb(0, `GIPS_OFS_POLARITY, 0);
        chk("polarity", rd, `GIPS_IMPL_BITS);
        srst <= 1;
        @(posedge clock);
        srst <= 0;
        apb(0, `GIPS_OFS_POLARITY, 0);
        chk("polarity", rd, `GIPS_RESUME_BITS);
        resume_well_reset <= 1;
        @(posedge clock);
        resume_well_reset <= 0;
        apb(0, `GIPS_OFS_POLARITY, 0);
        chk("polarity", rd, `GIPS_POLARITY_RST);
    endtask
    task automatic complete_run;
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        {srst, resume_well_reset} <= 2'b00;
        t_high();
        t_low();
        t_wells();
        complete_run();
    end
    // generous: the whole sequence needs well under 200 cycles
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
endmodule
